// file: src/fwoc_pkg.sv
// Package: register layout and constants for the flash write operation control block
package fwoc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [23:0] OPERATION_CONTROL_HIGH_ADDR = 24'h080002;
  localparam logic [15:0] OPERATION_CONTROL_HIGH_RST  = 16'h0000;

  // ------------------------------------------------------------
  // Field positions in the control high register
  // ------------------------------------------------------------
  localparam int WRITE_START_POS  = 15;
  localparam int SUSPEND_POS      = 14;
  localparam int WORD_PROG_POS    = 13;
  localparam int DWORD_PROG_POS   = 12;
  localparam int SECTOR_ERASE_POS = 11;
  localparam int PROTECT_PROG_POS = 8;

  // ------------------------------------------------------------
  // Protection register address window and erase values
  // ------------------------------------------------------------
  localparam logic [23:0] PROTECT_ADDR_LOW  = 24'h08DFB0;
  localparam logic [23:0] PROTECT_ADDR_HIGH = 24'h08DFBF;
  localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
  localparam logic [7:0]  PREPROG_BYTE      = 8'h00;
  localparam int          SECTOR_COUNT      = 8;

  // Operation kinds handed to the array
  typedef enum logic [2:0] {
    FWOC_OP_NONE,
    FWOC_OP_WORD,
    FWOC_OP_DWORD,
    FWOC_OP_ERASE,
    FWOC_OP_PROTECT
  } fwoc_op_t;

endpackage

// file: src/fwoc_top.sv
// Top: operation control high register and write sequencing of the flash controller
`timescale 1ns/10ps
`default_nettype none

module fwoc_top (
  input  wire logic        I_CLOCK,          // System clock, 200 MHz
  input  wire logic        I_ARST_N,         // Asynchronous reset, active low
  input  wire logic        I_CE,             // Clock enable, freezes all state when low
  input  wire logic        I_REG_WR,         // Register write strobe
  input  wire logic        I_REG_RD,         // Register read strobe
  input  wire logic [23:0] I_REG_ADDR,       // Register byte address
  input  wire logic [15:0] I_REG_WDATA,      // Register write data
  input  wire logic [1:0]  I_REG_BE,         // Byte enables, bit 1 is the upper byte
  input  wire logic [23:0] I_PROG_ADDR,      // Program address registers
  input  wire logic [7:0]  I_SECTOR_SEL,     // Sector select bits of bank 0
  input  wire logic        I_TEST_SEL,       // Test sector selected
  input  wire logic        I_WRITE_ERROR,    // Write error register error flag
  input  wire logic        I_BOOTSTRAP,      // Bootstrap mode
  input  wire logic        I_ARRAY_DONE,     // Array completion pulse
  input  wire logic        I_ARRAY_HALTED,   // Array acknowledges suspend
  output logic      [15:0] O_REG_RDATA,      // Register read data
  output logic             O_REG_TRAP,       // Read of a locked register, invalid data
  output logic             O_BANK_BUSY,      // Bank busy flag
  output logic             O_REG_LOCK,       // Register lock flag
  output logic             O_SEQ_ERROR,      // Sequence error pulse to error register
  output logic             O_ARRAY_GO,       // One-cycle start or resume to the array
  output logic       [2:0] O_ARRAY_OP,       // Operation kind for the array
  output logic             O_ARRAY_SUSPEND,  // Suspend request level to the array
  output logic             O_TEST_VISIBLE    // Test sector mapped for reads
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FWOC_IDLE,
    FWOC_RUN,
    FWOC_RUN_NOSUSP,
    FWOC_PROG_SUSPEND_REQUEST_BIT,
    FWOC_ERASE_SUSPEND_REQUEST_BIT
  } fwoc_state_t;

  fwoc_state_t state;
  logic write_start;
  logic suspend_req;
  logic word_program_select;
  logic double_word_program_select;
  logic sector_erase_select;
  logic protection_program_select;
  logic [15:0] ctrl_view;
  logic        hit_ctrl;
  logic        wr_ctrl;
  logic        wr_suspend_request_bit;
  logic        start_req;
  logic        start_ok;
  logic        addr_ok;
  logic [2:0]  sel_op;
  logic        sectors_ok;
  logic        op_allowed;
  logic        busy_state;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign hit_ctrl  = (I_REG_ADDR == fwoc_pkg::OPERATION_CONTROL_HIGH_ADDR);
  // Upper byte carries start/suspend/select; lock hides the register from writes
  assign wr_ctrl   = I_REG_WR && hit_ctrl && I_REG_BE[1] && !O_REG_LOCK;
  // Suspend must reach a running, locked operation, so it bypasses the lock
  assign wr_suspend_request_bit   = I_REG_WR && hit_ctrl && I_REG_BE[1] &&
                     I_REG_WDATA[fwoc_pkg::SUSPEND_POS];
  assign start_req = wr_ctrl && I_REG_WDATA[fwoc_pkg::WRITE_START_POS];
  assign addr_ok   = (I_PROG_ADDR >= fwoc_pkg::PROTECT_ADDR_LOW) &&
                     (I_PROG_ADDR <= fwoc_pkg::PROTECT_ADDR_HIGH);
  // Erase needs at least one sector and never the test sector
  assign sectors_ok = (I_SECTOR_SEL != 8'h00) && !I_TEST_SEL;

  // Operation encoded by the select bits of this write (first found wins)
  always_comb begin
    sel_op = fwoc_pkg::FWOC_OP_NONE;
    if (I_REG_WDATA[fwoc_pkg::WORD_PROG_POS]) begin
      sel_op = fwoc_pkg::FWOC_OP_WORD;
    end else if (I_REG_WDATA[fwoc_pkg::DWORD_PROG_POS]) begin
      sel_op = fwoc_pkg::FWOC_OP_DWORD;
    end else if (I_REG_WDATA[fwoc_pkg::SECTOR_ERASE_POS]) begin
      sel_op = fwoc_pkg::FWOC_OP_ERASE;
    end else if (I_REG_WDATA[fwoc_pkg::PROTECT_PROG_POS]) begin
      sel_op = fwoc_pkg::FWOC_OP_PROTECT;
    end
  end

  // Which starts each state accepts; suspend states only take the allowed kinds
  always_comb begin
    op_allowed = 1'b0;
    unique case (state)
      FWOC_IDLE:       op_allowed = (sel_op != fwoc_pkg::FWOC_OP_NONE) &&
                                    ((sel_op != fwoc_pkg::FWOC_OP_ERASE) || sectors_ok);
      FWOC_PROG_SUSPEND_REQUEST_BIT:  op_allowed = (sel_op == O_ARRAY_OP);
      FWOC_ERASE_SUSPEND_REQUEST_BIT: op_allowed = (sel_op == fwoc_pkg::FWOC_OP_ERASE) ||
                                    (sel_op == fwoc_pkg::FWOC_OP_WORD) ||
                                    (sel_op == fwoc_pkg::FWOC_OP_DWORD);
      FWOC_RUN:        op_allowed = 1'b0;
      FWOC_RUN_NOSUSP: op_allowed = 1'b0;
    endcase
  end

  // Error flag blocks every start; a protection start is still refused off-range
  assign start_ok = start_req && !I_WRITE_ERROR && op_allowed &&
                    !((sel_op == fwoc_pkg::FWOC_OP_PROTECT) && !addr_ok);

  assign busy_state = (state == FWOC_RUN) || (state == FWOC_RUN_NOSUSP);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Suspend only acts on a suspendable run; the array tells when it halted
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= FWOC_IDLE;
    end else if (I_CE) begin
      unique case (state)
        FWOC_IDLE, FWOC_PROG_SUSPEND_REQUEST_BIT: begin
          if (start_ok) begin
            state <= FWOC_RUN;
          end
        end
        FWOC_ERASE_SUSPEND_REQUEST_BIT: begin
          if (start_ok) begin
            // Programs started under erase suspend cannot be suspended
            state <= (sel_op == fwoc_pkg::FWOC_OP_ERASE) ? FWOC_RUN : FWOC_RUN_NOSUSP;
          end
        end
        FWOC_RUN: begin
          if (I_ARRAY_DONE) begin
            state <= FWOC_IDLE;
          end else if (I_ARRAY_HALTED && suspend_req) begin
            state <= (O_ARRAY_OP == fwoc_pkg::FWOC_OP_ERASE) ? FWOC_ERASE_SUSPEND_REQUEST_BIT : FWOC_PROG_SUSPEND_REQUEST_BIT;
          end
        end
        FWOC_RUN_NOSUSP: begin
          if (I_ARRAY_DONE) begin
            state <= FWOC_ERASE_SUSPEND_REQUEST_BIT;
          end
        end
      endcase
    end
  end

  // Write start: only set by an accepted start, cleared by done or suspend
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      write_start <= 1'b0;
    end else if (I_CE) begin
      if (start_ok) begin
        write_start <= 1'b1;
      end else if (busy_state && (I_ARRAY_DONE || (I_ARRAY_HALTED && suspend_req &&
                                                   state == FWOC_RUN))) begin
        write_start <= 1'b0;
      end
      // Software zero writes fall through untouched
    end
  end

  // Suspend bit: software set, kept during suspension, cleared by an accepted resume
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      suspend_req <= 1'b0;
    end else if (I_CE) begin
      if (wr_suspend_request_bit && state == FWOC_RUN && !I_ARRAY_DONE &&
          O_ARRAY_OP != fwoc_pkg::FWOC_OP_PROTECT) begin
        suspend_req <= 1'b1;
      end else if (state == FWOC_RUN && I_ARRAY_DONE) begin
        suspend_req <= 1'b0; // A finished run leaves nothing to suspend
      end else if (start_ok && state != FWOC_IDLE && state != FWOC_ERASE_SUSPEND_REQUEST_BIT) begin
        suspend_req <= 1'b0;
      end else if (start_ok && sel_op == fwoc_pkg::FWOC_OP_ERASE) begin
        suspend_req <= 1'b0;
      end else if (wr_ctrl && !I_REG_WDATA[fwoc_pkg::SUSPEND_POS] && state == FWOC_IDLE) begin
        suspend_req <= 1'b0;
      end
    end
  end

  // Select bits: writable while idle, cleared once their operation has finished
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      word_program_select        <= 1'b0;
      double_word_program_select <= 1'b0;
      sector_erase_select        <= 1'b0;
      protection_program_select  <= 1'b0;
    end else if (I_CE) begin
      if (busy_state && I_ARRAY_DONE) begin
        word_program_select        <= 1'b0;
        double_word_program_select <= 1'b0;
        sector_erase_select        <= (state == FWOC_RUN_NOSUSP);
        protection_program_select  <= 1'b0;
      end else if (wr_ctrl && !busy_state) begin
        word_program_select        <= I_REG_WDATA[fwoc_pkg::WORD_PROG_POS];
        double_word_program_select <= I_REG_WDATA[fwoc_pkg::DWORD_PROG_POS];
        sector_erase_select        <= I_REG_WDATA[fwoc_pkg::SECTOR_ERASE_POS] ||
                                      (state == FWOC_ERASE_SUSPEND_REQUEST_BIT);
        protection_program_select  <= I_REG_WDATA[fwoc_pkg::PROTECT_PROG_POS];
      end
    end
  end

  // ------------------------------------------------------------
  // Array side outputs
  // ------------------------------------------------------------
  // Erase kind tells the array to pre-program zeros then erase to the erased byte
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ARRAY_GO      <= 1'b0;
      O_ARRAY_OP      <= fwoc_pkg::FWOC_OP_NONE;
      O_ARRAY_SUSPEND <= 1'b0;
    end else if (I_CE) begin
      O_ARRAY_GO <= start_ok;
      if (start_ok) begin
        O_ARRAY_OP <= sel_op;
      end
      O_ARRAY_SUSPEND <= (suspend_req || wr_suspend_request_bit) &&
                         state == FWOC_RUN && O_ARRAY_OP != fwoc_pkg::FWOC_OP_PROTECT;
    end
  end

  // Busy and lock follow the write start; suspension drops both
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_BANK_BUSY <= 1'b0;
      O_REG_LOCK  <= 1'b0;
    end else if (I_CE) begin
      if (start_ok) begin
        O_BANK_BUSY <= 1'b1;
        O_REG_LOCK  <= 1'b1;
      end else if (busy_state && (I_ARRAY_DONE || (I_ARRAY_HALTED && suspend_req &&
                                                   state == FWOC_RUN))) begin
        O_BANK_BUSY <= 1'b0;
        O_REG_LOCK  <= 1'b0;
      end
    end
  end

  // Off-range protection address flags the sequence error for one cycle
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SEQ_ERROR <= 1'b0;
    end else if (I_CE) begin
      O_SEQ_ERROR <= start_req && !I_WRITE_ERROR && (state == FWOC_IDLE) &&
                     (sel_op == fwoc_pkg::FWOC_OP_PROTECT) && !addr_ok;
    end
  end

  // Test sector mapping follows bootstrap mode only
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_TEST_VISIBLE <= 1'b0;
    end else if (I_CE) begin
      O_TEST_VISIBLE <= I_BOOTSTRAP;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  assign ctrl_view = {write_start, suspend_req, word_program_select,
                      double_word_program_select, sector_erase_select, 2'b00,
                      protection_program_select, 8'h00};

  // Locked reads return all ones and a trap; unmapped reads return zero
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_REG_RDATA <= fwoc_pkg::OPERATION_CONTROL_HIGH_RST;
      O_REG_TRAP  <= 1'b0;
    end else if (I_CE) begin
      O_REG_TRAP  <= I_REG_RD && hit_ctrl && O_REG_LOCK;
      if (I_REG_RD && hit_ctrl) begin
        O_REG_RDATA <= O_REG_LOCK ? 16'hFFFF : ctrl_view;
      end else if (I_REG_RD) begin
        O_REG_RDATA <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_start_busy: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && start_ok |=> O_BANK_BUSY && O_REG_LOCK && write_start)
    else $error("start did not set busy and lock");
  chk_error_blocks: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && I_WRITE_ERROR && state == FWOC_IDLE |=> !O_ARRAY_GO)
    else $error("start taken while error flag high");
  chk_done_clears: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_RUN && I_ARRAY_DONE |=> !write_start && !O_BANK_BUSY &&
    !word_program_select && !double_word_program_select && !protection_program_select)
    else $error("completion left start or select set");
  chk_zero_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && write_start && !I_ARRAY_DONE && !I_ARRAY_HALTED |=> write_start)
    else $error("write start cleared without completion");
  chk_seq_error: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_SEQ_ERROR |-> $past(sel_op) == fwoc_pkg::FWOC_OP_PROTECT && !$past(addr_ok))
    else $error("sequence error without bad protection address");
  chk_suspend_idle: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_RUN && suspend_req && I_ARRAY_HALTED && !I_ARRAY_DONE
    |=> !O_BANK_BUSY && !write_start)
    else $error("suspend did not release the bank");
  chk_prog_suspend_request_bit: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_PROG_SUSPEND_REQUEST_BIT && sel_op == fwoc_pkg::FWOC_OP_ERASE |=> !O_ARRAY_GO)
    else $error("erase accepted during program suspend");
  chk_locked_trap: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && I_REG_RD && hit_ctrl && O_REG_LOCK |=> O_REG_TRAP && O_REG_RDATA == 16'hFFFF)
    else $error("locked read not trapped");
  chk_nosusp_run: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_RUN_NOSUSP |=> !O_ARRAY_SUSPEND)
    else $error("suspend requested for an unsuspendable program");
  chk_erase_clears: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_RUN && I_ARRAY_DONE |=> !sector_erase_select)
    else $error("erase select left set after completion");
  chk_test_refused: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_CE && state == FWOC_IDLE && I_TEST_SEL && sel_op == fwoc_pkg::FWOC_OP_ERASE
    |=> !O_ARRAY_GO)
    else $error("erase started with the test sector selected");

endmodule

`default_nettype wire

// file: testbench/fwoc_tb_top.sv
// Testbench: register-level sequences for the flash write operation control block
`timescale 1ns/10ps
`default_nettype none

module fwoc_tb_top;
  // ------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------
  logic        clk;
  logic        arst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [23:0] prog_addr;
  logic [7:0]  sector_sel;
  logic        test_sel;
  logic        write_error;
  logic        bootstrap;
  logic        array_done;
  logic        array_halted;
  logic [15:0] reg_rdata;
  logic        reg_trap;
  logic        bank_busy;
  logic        reg_lock;
  logic        seq_error;
  logic        array_go;
  logic [2:0]  array_op;
  logic        array_suspend;
  logic        test_visible;
  logic        go_seen;
  logic [2:0]  op_seen;
  logic        seq_seen;
  int          n_mismatch;
  int          comparisons;

  fwoc_top uut (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .I_CE(1'b1), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_BE(2'h3),
    .I_PROG_ADDR(prog_addr), .I_SECTOR_SEL(sector_sel), .I_TEST_SEL(test_sel),
    .I_WRITE_ERROR(write_error), .I_BOOTSTRAP(bootstrap), .I_ARRAY_DONE(array_done),
    .I_ARRAY_HALTED(array_halted), .O_REG_RDATA(reg_rdata), .O_REG_TRAP(reg_trap),
    .O_BANK_BUSY(bank_busy), .O_REG_LOCK(reg_lock), .O_SEQ_ERROR(seq_error),
    .O_ARRAY_GO(array_go), .O_ARRAY_OP(array_op), .O_ARRAY_SUSPEND(array_suspend),
    .O_TEST_VISIBLE(test_visible)
  );

  // ------------------------------------------------------------
  // Clock, compare and bus tasks
  // ------------------------------------------------------------
  // 200 MHz system clock
  always #2.5 clk = ~clk;

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One-cycle write strobe; the go pulse lands in the cycle after the taking edge
  task automatic wr(input logic [15:0] data);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_wdata = data;
    @(negedge clk);
    reg_wr   = 1'b0;
    go_seen  = array_go;
    op_seen  = array_op;
    seq_seen = seq_error;
  endtask

  // Read data and trap are registered, so both are looked at one cycle on
  task automatic rd(input logic [15:0] exp, input logic trap);
    @(negedge clk);
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk16("read data", exp, reg_rdata);
    chk1("read trap", trap, reg_trap);
  endtask

  // Completion (halt=0) or suspend acknowledge (halt=1) from the array, one cycle
  task automatic finish_op(input logic halt);
    @(negedge clk);
    array_halted = halt;
    array_done   = ~halt;
    @(negedge clk);
    array_halted = 1'b0;
    array_done   = 1'b0;
  endtask

  task automatic status(input logic busy, input logic lock);
    chk1("bank busy", busy, bank_busy);
    chk1("register lock", lock, reg_lock);
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  // Watchdog: the sequence needs about 120 cycles, so 20 us means a hang
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end

  initial begin
    clk = 1'b0; arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 16'h0000;
    reg_addr = fwoc_pkg::OPERATION_CONTROL_HIGH_ADDR; prog_addr = 24'h000000;
    sector_sel = 8'h01; test_sel = 1'b0; write_error = 1'b0; bootstrap = 1'b0;
    array_done = 1'b0; array_halted = 1'b0; n_mismatch = 0; comparisons = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    rd(fwoc_pkg::OPERATION_CONTROL_HIGH_RST, 1'b0);
    chk1("test visible", 1'b0, test_visible);
    bootstrap = 1'b1;
    repeat (2) @(negedge clk);
    chk1("test visible", 1'b1, test_visible);
    // A select alone must not launch anything, and stays readable
    wr(16'h2000);
    chk1("go", 1'b0, go_seen);
    rd(16'h2000, 1'b0);
    wr(16'h0000);
    // Start at an unmapped address and with the error flag high is ignored
    reg_addr = 24'h080000;
    wr(16'hA000);
    chk1("go", 1'b0, go_seen);
    reg_addr = fwoc_pkg::OPERATION_CONTROL_HIGH_ADDR;
    write_error = 1'b1;
    wr(16'hA000);
    chk1("go", 1'b0, go_seen);
    write_error = 1'b0;
    wr(16'h0000);
    // Word program, with lock behaviour and self-clearing bits
    wr(16'hA000);
    chk1("go", 1'b1, go_seen);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_WORD), 16'(op_seen));
    status(1'b1, 1'b1);
    rd(16'hFFFF, 1'b1);
    wr(16'h0000);
    status(1'b1, 1'b1);
    finish_op(1'b0);
    status(1'b0, 1'b0);
    rd(16'h0000, 1'b0);
    // Double word program
    wr(16'h9000);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_DWORD), 16'(op_seen));
    finish_op(1'b0);
    rd(16'h0000, 1'b0);
    // Sector erase, then refused with the test sector selected
    wr(16'h8800);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_ERASE), 16'(op_seen));
    finish_op(1'b0);
    rd(16'h0000, 1'b0);
    test_sel = 1'b1;
    wr(16'h8800);
    chk1("go", 1'b0, go_seen);
    test_sel = 1'b0;
    wr(16'h0000);
    // Erase with no sector marked is refused as well
    sector_sel = 8'h00;
    wr(16'h8800);
    chk1("go", 1'b0, go_seen);
    sector_sel = 8'h01;
    wr(16'h0000);
    // Protection programming at both window edges, then just outside it
    for (int i = 0; i < 2; i++) begin
      prog_addr = i ? fwoc_pkg::PROTECT_ADDR_HIGH : fwoc_pkg::PROTECT_ADDR_LOW;
      wr(16'h8100);
      chk16("op", 16'(fwoc_pkg::FWOC_OP_PROTECT), 16'(op_seen));
      chk1("seq error", 1'b0, seq_seen);
      finish_op(1'b0);
      rd(16'h0000, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      prog_addr = i ? fwoc_pkg::PROTECT_ADDR_HIGH + 24'h1 : fwoc_pkg::PROTECT_ADDR_LOW - 24'h1;
      wr(16'h8100);
      chk1("seq error", 1'b1, seq_seen);
      chk1("go", 1'b0, go_seen);
      wr(16'h0000);
    end
    // Program suspend: only a resume of the same program kind is accepted
    wr(16'hA000);
    wr(16'h6000);
    chk1("suspend request", 1'b1, array_suspend);
    finish_op(1'b1);
    status(1'b0, 1'b0);
    rd(16'h6000, 1'b0);
    wr(16'hC800);
    chk1("go", 1'b0, go_seen);
    wr(16'h9000);
    chk1("go", 1'b0, go_seen);
    wr(16'hA000);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_WORD), 16'(op_seen));
    finish_op(1'b0);
    // Erase suspend: a program may run but cannot itself be suspended
    wr(16'h8800);
    wr(16'h4800);
    finish_op(1'b1);
    status(1'b0, 1'b0);
    wr(16'hA800);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_WORD), 16'(op_seen));
    wr(16'h6800);
    chk1("suspend request", 1'b0, array_suspend);
    finish_op(1'b0);
    wr(16'h8800);
    chk16("op", 16'(fwoc_pkg::FWOC_OP_ERASE), 16'(op_seen));
    finish_op(1'b0);
    rd(16'h0000, 1'b0);
    close_out();
  end
endmodule

`default_nettype wire
